// *** rtl/cdd_top.sv ***
// How it works
// - Zero-delay mode code 01 selects internal zero-delay feedback.
// - Internal zero-delay feeds channel divider 0 to the PLL feedback divider.
// - Zero-delay mode code 11 takes feedback from the looped-back CLK pin.
// - Two-bit field picks feedback divider 0..3, default 0, for VCO calibration.
// - Four channels, each divider shared by three outputs.
// - Each channel divider divides by any integer 1 to 32.
// - Output high for high count plus one, low for low count plus one.
// - Optional duty correction evens odd ratios only when low equals high plus one.
// - Coarse phase delay up to 15 divider input cycles.
// - Each divider can start high or start low.
// - Prescaler divides selected source by 1 to 6, also usable with CLK.
// - Source 00 CLK via prescaler, 01 CLK direct, 10 VCO via prescaler, 11 illegal.
// - No setting lets the VCO reach dividers without the prescaler.
// - Direct bit routes prescaler input straight to that group's three outputs.
// - All channel dividers stay synchronized to each other.
// - Bypass bit gives divide by one, skipping the divider.
// - High and low count fields are four bits each, 0 to 15.
`timescale 1ns/10ps
`default_nettype none
module cdd_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        vco_clk_in,
  input  wire logic        ext_clk_in,
  output logic [11:0]      clk_out,
  output logic             pll_fb_out,
  output logic             zd_active,
  output logic [1:0]       fb_channel
);

  typedef struct packed {
    logic             awa;
    logic [9:0]       aw_idx;
    logic             wa;
    logic [31:0]      wdat;
    logic             wbe;
    logic             awrdy;
    logic             wrdy;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arrdy;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic [1:0]       zd_mode;
    logic [1:0]       fb_ch;
    logic [2:0]       pre_sel;
    logic [1:0]       src;
    logic [3:0][3:0]  ch_n;
    logic [3:0][3:0]  ch_m;
    logic [3:0][3:0]  ch_ph;
    logic [3:0]       ch_byp;
    logic [3:0]       ch_start;
    logic [3:0]       ch_dccd;
    logic [3:0]       ch_dir;
    logic             sync_req;
    logic             booted;
    logic [2:0]       vco_s;
    logic [2:0]       ext_s;
    logic [2:0]       pre_cnt;
    logic             pre_lvl;
    logic             half_tick;
    logic [11:0]      out_q;
    logic             fb_q;
    logic             zd_q;
  } cdd_top_st_t;

  cdd_top_st_t st_r;
  cdd_top_st_t st_nxt;
  logic [3:0]  div_q;
  logic        sel_edge;
  logic        sel_lvl;
  logic        dist_lvl;
  logic        div_sync;
  logic        wr_fire;

  // Channel register decode: {hit, channel, sub-register}
  function automatic logic [4:0] ch_dec(input logic [9:0] idx);
    ch_dec = 5'h00;
    for (int c = 0; c < cdd_pkg::NUM_CH; c++) begin
      for (int s = 0; s < 3; s++) begin
        if (idx == cdd_pkg::IDX_CH_BASE + 10'(c) * cdd_pkg::IDX_CH_STRIDE + 10'(s)) begin
          ch_dec = {1'b1, 2'(c), 2'(s)};
        end
      end
    end
  endfunction

  // Register read mux: {hit, data}
  function automatic logic [32:0] reg_read(input cdd_top_st_t s, input logic [9:0] idx, input logic [3:0] dq);
    logic [4:0] d;
    logic [1:0] c;
    d = ch_dec(idx);
    c = d[3:2];
    reg_read = {1'b1, 32'h0};
    if (d[4]) begin
      unique case (d[1:0])
        2'h0:    reg_read[7:0] = {s.ch_m[c], s.ch_n[c]};
        2'h1:    reg_read[7:0] = {s.ch_byp[c], 2'h0, s.ch_start[c], s.ch_ph[c]};
        default: reg_read[7:0] = {6'h00, s.ch_dir[c], s.ch_dccd[c]};
      endcase
    end else if (idx == cdd_pkg::IDX_ZD_CFG) begin
      reg_read[cdd_pkg::ZD_MODE_LSB +: 2] = s.zd_mode;
      reg_read[cdd_pkg::ZD_FB_LSB +: 2]   = s.fb_ch;
    end else if (idx == cdd_pkg::IDX_PRE_DIV) begin
      reg_read[cdd_pkg::PRE_W-1:0] = s.pre_sel;
    end else if (idx == cdd_pkg::IDX_SRC_SEL) begin
      reg_read[1:0] = s.src;
    end else if (idx == cdd_pkg::IDX_STATUS) begin
      reg_read[cdd_pkg::ST_ZD_LSB +: 2] = s.zd_mode;
      reg_read[cdd_pkg::ST_BAD]          = (s.src == cdd_pkg::SRC_BAD);
      reg_read[cdd_pkg::ST_DIV_LSB +: 4] = dq;
    end else if (idx != cdd_pkg::IDX_SYNC) begin
      reg_read[32] = 1'b0;
    end
  endfunction

  // Source pick; bit 1 of each chain is past the synchroniser
  // Illegal code parks the level too, so direct groups stay quiet as well
  assign sel_lvl  = (st_r.src == cdd_pkg::SRC_VCO_PRE) ? st_r.vco_s[1]
                  : (st_r.src == cdd_pkg::SRC_BAD)     ? 1'b0
                  : st_r.ext_s[1];
  assign sel_edge = (st_r.src == cdd_pkg::SRC_VCO_PRE) ? (st_r.vco_s[1] ^ st_r.vco_s[2])
                  : (st_r.src == cdd_pkg::SRC_BAD)     ? 1'b0
                  : (st_r.ext_s[1] ^ st_r.ext_s[2]);
  // Prescaler bypass only on the CLK-direct code, never for the VCO
  assign dist_lvl = (st_r.src == cdd_pkg::SRC_CLK_DIR) ? sel_lvl : st_r.pre_lvl;
  assign div_sync = st_r.sync_req || !st_r.booted;
  // Write completes this cycle; taken from inputs since st_nxt clears the halves
  assign wr_fire  = (st_r.awa || (s_axi_awvalid && st_r.awrdy))
                 && (st_r.wa || (s_axi_wvalid && st_r.wrdy)) && !st_r.bvalid;

  always_comb begin
    logic [4:0]  d;
    logic [32:0] rd;
    d  = 5'h00;
    rd = 33'h0;
    st_nxt = st_r;
    st_nxt.sync_req = 1'b0;
    st_nxt.booted   = 1'b1;

    // Pin synchronisers and third stage for edge detection
    st_nxt.vco_s = {st_r.vco_s[1:0], vco_clk_in};
    st_nxt.ext_s = {st_r.ext_s[1:0], ext_clk_in};

    // Prescaler counts source half-cycles, toggling every k+1 of them
    st_nxt.half_tick = 1'b0;
    if (st_r.src == cdd_pkg::SRC_CLK_DIR) begin
      st_nxt.half_tick = sel_edge;
    end else if (sel_edge && st_r.pre_sel <= cdd_pkg::PRE_LAST) begin
      if (st_r.pre_cnt >= st_r.pre_sel) begin
        st_nxt.pre_cnt   = 3'h0;
        st_nxt.pre_lvl   = !st_r.pre_lvl;
        st_nxt.half_tick = 1'b1;
      end else begin
        st_nxt.pre_cnt = st_r.pre_cnt + 3'h1;
      end
    end

    // Write address and data taken in either order
    if (s_axi_awvalid && st_r.awrdy) begin
      st_nxt.awa    = 1'b1;
      st_nxt.aw_idx = s_axi_awaddr[cdd_pkg::IDX_LSB +: 10];
    end
    if (s_axi_wvalid && st_r.wrdy) begin
      st_nxt.wa   = 1'b1;
      st_nxt.wdat = s_axi_wdata;
      st_nxt.wbe  = s_axi_wstrb[0];
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (st_nxt.awa && st_nxt.wa && !st_r.bvalid) begin
      st_nxt.awa    = 1'b0;
      st_nxt.wa     = 1'b0;
      st_nxt.bvalid = 1'b1;
      d = ch_dec(st_nxt.aw_idx);
      rd = reg_read(st_r, st_nxt.aw_idx, div_q);
      st_nxt.bresp = rd[32] ? cdd_pkg::RESP_OKAY : cdd_pkg::RESP_SLVERR;
      if (st_nxt.wbe) begin
        if (d[4]) begin
          unique case (d[1:0])
            2'h0: begin
              st_nxt.ch_n[d[3:2]] = st_nxt.wdat[cdd_pkg::CH_N_LSB +: 4];
              st_nxt.ch_m[d[3:2]] = st_nxt.wdat[cdd_pkg::CH_M_LSB +: 4];
            end
            2'h1: begin
              st_nxt.ch_ph[d[3:2]]    = st_nxt.wdat[cdd_pkg::CH_PH_LSB +: 4];
              st_nxt.ch_start[d[3:2]] = st_nxt.wdat[cdd_pkg::CH_START];
              st_nxt.ch_byp[d[3:2]]   = st_nxt.wdat[cdd_pkg::CH_BYP];
            end
            default: begin
              st_nxt.ch_dccd[d[3:2]] = st_nxt.wdat[cdd_pkg::CH_DCC_DIS];
              st_nxt.ch_dir[d[3:2]]  = st_nxt.wdat[cdd_pkg::CH_DIRECT];
            end
          endcase
        end else if (st_nxt.aw_idx == cdd_pkg::IDX_ZD_CFG) begin
          st_nxt.zd_mode = st_nxt.wdat[cdd_pkg::ZD_MODE_LSB +: 2];
          st_nxt.fb_ch   = st_nxt.wdat[cdd_pkg::ZD_FB_LSB +: 2];
        end else if (st_nxt.aw_idx == cdd_pkg::IDX_PRE_DIV) begin
          st_nxt.pre_sel = st_nxt.wdat[cdd_pkg::PRE_W-1:0];
        end else if (st_nxt.aw_idx == cdd_pkg::IDX_SRC_SEL) begin
          st_nxt.src = st_nxt.wdat[1:0];
        end else if (st_nxt.aw_idx == cdd_pkg::IDX_SYNC) begin
          st_nxt.sync_req = st_nxt.wdat[0];
        end
      end
    end

    // Read path: one read outstanding, answered the next cycle
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_r.arrdy) begin
      rd = reg_read(st_r, s_axi_araddr[cdd_pkg::IDX_LSB +: 10], div_q);
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = rd[31:0];
      st_nxt.rresp  = rd[32] ? cdd_pkg::RESP_OKAY : cdd_pkg::RESP_SLVERR;
    end
    st_nxt.awrdy = !st_nxt.awa && !st_nxt.bvalid;
    st_nxt.wrdy  = !st_nxt.wa && !st_nxt.bvalid;
    st_nxt.arrdy = !st_nxt.rvalid;

    // Each group's three outputs share one divider or the direct path
    for (int g = 0; g < cdd_pkg::NUM_CH; g++) begin
      for (int k = 0; k < cdd_pkg::OUT_PER_GRP; k++) begin
        st_nxt.out_q[g * cdd_pkg::OUT_PER_GRP + k] = st_r.ch_dir[g] ? sel_lvl : div_q[g];
      end
    end

    // Internal mode only ever loops divider 0; other channels go off-chip
    st_nxt.zd_q = (st_r.zd_mode == cdd_pkg::ZD_INT) || (st_r.zd_mode == cdd_pkg::ZD_EXT);
    if (st_r.zd_mode == cdd_pkg::ZD_INT) begin
      st_nxt.fb_q = div_q[0];
    end else if (st_r.zd_mode == cdd_pkg::ZD_EXT) begin
      st_nxt.fb_q = st_r.ext_s[1];
    end else begin
      st_nxt.fb_q = st_r.vco_s[1];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r         <= '0;
      st_r.awrdy   <= 1'b1;
      st_r.wrdy    <= 1'b1;
      st_r.arrdy   <= 1'b1;
      st_r.src     <= cdd_pkg::RST_SRC;
      st_r.pre_sel <= cdd_pkg::RST_PRE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Four dividers share one tick and one sync, keeping them aligned
  for (genvar c = 0; c < cdd_pkg::NUM_CH; c++) begin : g_div
    cdd_chan_div u_div (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .half_tick  (st_r.half_tick),
      .in_level   (dist_lvl),
      .sync       (div_sync),
      .cnt_high   (st_r.ch_n[c]),
      .cnt_low    (st_r.ch_m[c]),
      .bypass     (st_r.ch_byp[c]),
      .dcc_dis    (st_r.ch_dccd[c]),
      .phase      (st_r.ch_ph[c]),
      .start_high (st_r.ch_start[c]),
      .div_out    (div_q[c])
    );
  end

  assign s_axi_awready = st_r.awrdy;
  assign s_axi_wready  = st_r.wrdy;
  assign s_axi_bvalid  = st_r.bvalid;
  assign s_axi_bresp   = st_r.bresp;
  assign s_axi_arready = st_r.arrdy;
  assign s_axi_rvalid  = st_r.rvalid;
  assign s_axi_rdata   = st_r.rdata;
  assign s_axi_rresp   = st_r.rresp;
  assign clk_out       = st_r.out_q;
  assign pll_fb_out    = st_r.fb_q;
  assign zd_active     = st_r.zd_q;
  assign fb_channel    = st_r.fb_ch;

  a_src_bad_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r.src == cdd_pkg::SRC_BAD) |=> !st_r.half_tick)
    else $error("clock reached dividers with illegal source");
  a_int_zd_route: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r.zd_mode == cdd_pkg::ZD_INT) |=> (pll_fb_out == $past(div_q[0])) && zd_active)
    else $error("internal feedback not from divider 0");
  a_ext_zd_route: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r.zd_mode == cdd_pkg::ZD_EXT) |=> (pll_fb_out == $past(st_r.ext_s[1])))
    else $error("external feedback not from CLK pin");
  a_direct_route: assert property (@(posedge aclk) disable iff (!aresetn)
    st_r.ch_dir[2] |=> (clk_out[8:6] == {3{$past(sel_lvl)}}))
    else $error("direct group 2 not following source");
  a_fb_chan_write: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && st_nxt.wbe && st_nxt.aw_idx == cdd_pkg::IDX_ZD_CFG)
      |=> (fb_channel == $past(st_nxt.wdat[cdd_pkg::ZD_FB_LSB +: 2])))
    else $error("feedback channel field not written");
  a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");

endmodule
`default_nettype wire

// *** rtl/cdd_pkg.sv ***
package cdd_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_ZD_CFG    = 10'h01e;
  localparam logic [9:0] IDX_PRE_DIV   = 10'h1e0;
  localparam logic [9:0] IDX_SRC_SEL   = 10'h1e1;
  localparam logic [9:0] IDX_CH_BASE   = 10'h190;
  localparam logic [9:0] IDX_CH_STRIDE = 10'h003;
  localparam logic [9:0] IDX_SYNC      = 10'h1f0;
  localparam logic [9:0] IDX_STATUS    = 10'h1f1;
  localparam int unsigned IDX_LSB      = 2;

  // Zero-delay configuration fields
  localparam int unsigned ZD_MODE_LSB = 1;
  localparam int unsigned ZD_FB_LSB   = 3;
  localparam logic [1:0]  ZD_INT      = 2'h1;
  localparam logic [1:0]  ZD_EXT      = 2'h3;

  // Distribution source codes
  localparam logic [1:0] SRC_CLK_PRE = 2'h0;
  localparam logic [1:0] SRC_CLK_DIR = 2'h1;
  localparam logic [1:0] SRC_VCO_PRE = 2'h2;
  localparam logic [1:0] SRC_BAD     = 2'h3;

  // Prescaler code k divides by k+1; codes above the last are static
  localparam int unsigned PRE_W    = 3;
  localparam logic [2:0]  PRE_LAST = 3'h5;

  // Channel register fields (sub-register 0, 1, 2)
  localparam int unsigned CH_N_LSB    = 0;
  localparam int unsigned CH_M_LSB    = 4;
  localparam int unsigned CH_PH_LSB   = 0;
  localparam int unsigned CH_START    = 4;
  localparam int unsigned CH_BYP      = 7;
  localparam int unsigned CH_DCC_DIS  = 0;
  localparam int unsigned CH_DIRECT   = 1;
  localparam int unsigned NUM_CH      = 4;
  localparam int unsigned OUT_PER_GRP = 3;

  // Status fields
  localparam int unsigned ST_ZD_LSB  = 0;
  localparam int unsigned ST_BAD     = 2;
  localparam int unsigned ST_DIV_LSB = 4;

  // Reset values
  localparam logic [1:0] RST_SRC = 2'h2;
  localparam logic [2:0] RST_PRE = 3'h1;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** rtl/cdd_chan_div.sv ***
`timescale 1ns/10ps
`default_nettype none
module cdd_chan_div (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       half_tick,
  input  wire logic       in_level,
  input  wire logic       sync,
  input  wire logic [3:0] cnt_high,
  input  wire logic [3:0] cnt_low,
  input  wire logic       bypass,
  input  wire logic       dcc_dis,
  input  wire logic [3:0] phase,
  input  wire logic       start_high,
  output logic            div_out
);

  typedef struct packed {
    logic       lvl;
    logic [5:0] cnt;
    logic [4:0] dly;
    logic       out;
  } cdd_div_st_t;

  cdd_div_st_t st_r;
  cdd_div_st_t st_nxt;

  // Length of one level in input half-cycles; correction evens odd splits
  function automatic logic [5:0] half_len(input logic hi, input logic [3:0] n, input logic [3:0] m,
                                          input logic dcc_on);
    logic [5:0] sum;
    sum = {2'h0, n} + {2'h0, m} + 6'h02;
    if (dcc_on && ({1'b0, m} == {1'b0, n} + 5'h01)) begin
      half_len = sum;
    end else if (hi) begin
      half_len = {1'b0, n, 1'b0} + 6'h02;
    end else begin
      half_len = {1'b0, m, 1'b0} + 6'h02;
    end
  endfunction

  // Counts half-cycles so odd ratios can be split evenly
  always_comb begin
    st_nxt = st_r;
    if (sync) begin
      st_nxt.lvl = start_high;
      st_nxt.cnt = half_len(start_high, cnt_high, cnt_low, !dcc_dis) - 6'h01;
      st_nxt.dly = {phase, 1'b0};
    end else if (half_tick) begin
      if (st_r.dly != 5'h00) begin
        st_nxt.dly = st_r.dly - 5'h01;
      end else if (st_r.cnt == 6'h00) begin
        st_nxt.lvl = !st_r.lvl;
        st_nxt.cnt = half_len(!st_r.lvl, cnt_high, cnt_low, !dcc_dis) - 6'h01;
      end else begin
        st_nxt.cnt = st_r.cnt - 6'h01;
      end
    end
    st_nxt.out = bypass ? in_level : st_nxt.lvl;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign div_out = st_r.out;

  a_delay_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (!sync && !bypass && st_r.dly != 5'h00) |=> $stable(st_r.lvl))
    else $error("divider level moved during phase delay");
  a_sync_start: assert property (@(posedge aclk) disable iff (!aresetn)
    sync |=> (st_r.lvl == $past(start_high)) && (st_r.dly == {$past(phase), 1'b0}))
    else $error("sync did not restart divider");
  a_bypass_pass: assert property (@(posedge aclk) disable iff (!aresetn)
    bypass |=> (div_out == $past(in_level)))
    else $error("bypassed divider not following input");
  a_level_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
    (!sync && half_tick && st_r.dly == 5'h00 && st_r.cnt == 6'h00) |=> (st_r.lvl != $past(st_r.lvl)))
    else $error("divider missed level change");

endmodule
`default_nettype wire

// *** testbench/clock_distribution_divider_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module clock_distribution_divider_bench;
  logic        aclk;
  logic        aresetn;
  logic [11:0] awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [11:0] araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        vco_clk_in;
  logic        ext_clk_in;
  logic [11:0] clk_out;
  logic        pll_fb_out;
  logic        zd_active;
  logic [1:0]  fb_channel;
  logic [3:0]  ext_cnt;
  logic [3:0]  vco_cnt;
  int          errors;
  int          n_tests;

  cdd_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .vco_clk_in(vco_clk_in),
    .ext_clk_in(ext_clk_in), .clk_out(clk_out), .pll_fb_out(pll_fb_out), .zd_active(zd_active),
    .fb_channel(fb_channel));

  // 50 ns clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // Pin clocks: half period 5 cycles on the external pin, 6 on the oscillator pin
  always @(posedge aclk) begin
    ext_cnt <= (ext_cnt == 4'h4) ? 4'h0 : ext_cnt + 4'h1;
    vco_cnt <= (vco_cnt == 4'h5) ? 4'h0 : vco_cnt + 4'h1;
    if (ext_cnt == 4'h4) ext_clk_in <= ~ext_clk_in;
    if (vco_cnt == 4'h5) vco_clk_in <= ~vco_clk_in;
  end

  task automatic test_done;
    if (errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Write one register; address and data offered together, response awaited
  task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
    int i;
    @(posedge aclk);
    awaddr <= {idx, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        chk({30'h0, bresp}, {30'h0, er});
        bready <= 1'b0;
        break;
      end
    end
    if (i == 100) begin errors++; test_done; end
  endtask

  task automatic rd(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge aclk);
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (i == 100) begin errors++; test_done; end
  endtask

  task automatic rd_chk(input logic [9:0] idx, input logic [31:0] mask, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(idx, d, r);
    chk({30'h0, r}, {30'h0, cdd_pkg::RESP_OKAY});
    chk(d & mask, e);
  endtask

  function automatic logic sig(input int idx);
    return (idx == 12) ? pll_fb_out : clk_out[idx];
  endfunction

  // Counts edges until the watched output shows the level
  task automatic wait_lvl(input int idx, input logic lvl, output int n);
    for (n = 1; n < 600; n++) begin
      @(posedge aclk);
      if (sig(idx) === lvl) break;
    end
    if (n == 600) begin errors++; test_done; end
  endtask

  // Second of two measured periods is judged; the first may be cut by a reconfiguration
  task automatic chk_wave(input int idx, input int hi, input int lo);
    int c;
    int h;
    int l;
    repeat (2) begin
      wait_lvl(idx, 1'b0, c);
      wait_lvl(idx, 1'b1, c);
      wait_lvl(idx, 1'b0, h);
      wait_lvl(idx, 1'b1, l);
    end
    chk(32'(h), 32'(hi));
    chk(32'(l), 32'(lo));
  endtask

  task automatic set_ch(input logic [1:0] c, input logic [7:0] r0, input logic [7:0] r1,
                        input logic [7:0] r2);
    logic [9:0] b;
    b = cdd_pkg::IDX_CH_BASE + cdd_pkg::IDX_CH_STRIDE * {8'h0, c};
    wr(b, r0, cdd_pkg::RESP_OKAY);
    wr(b + 10'h001, r1, cdd_pkg::RESP_OKAY);
    wr(b + 10'h002, r2, cdd_pkg::RESP_OKAY);
    wr(cdd_pkg::IDX_SYNC, 8'h01, cdd_pkg::RESP_OKAY);
  endtask

  task automatic test_reset;
    rd_chk(cdd_pkg::IDX_ZD_CFG, 32'hffffffff, 32'h0);
    rd_chk(cdd_pkg::IDX_PRE_DIV, 32'hffffffff, 32'h1);
    rd_chk(cdd_pkg::IDX_SRC_SEL, 32'hffffffff, 32'h2);
    chk({30'h0, fb_channel}, 32'h0);
    chk({31'h0, zd_active}, 32'h0);
    chk_wave(0, 24, 24);
  endtask

  task automatic test_unmapped;
    logic [31:0] d;
    logic [1:0]  r;
    wr(10'h100, 8'h5a, cdd_pkg::RESP_SLVERR);
    rd(10'h100, d, r);
    chk({30'h0, r}, {30'h0, cdd_pkg::RESP_SLVERR});
    chk(d, 32'h0);
  endtask

  // External pin through every prescaler ratio, channel dividing by two
  task automatic test_prescale;
    wr(cdd_pkg::IDX_SRC_SEL, 8'h00, cdd_pkg::RESP_OKAY);
    for (int k = 0; k < 6; k++) begin
      wr(cdd_pkg::IDX_PRE_DIV, 8'(k), cdd_pkg::RESP_OKAY);
      chk_wave(0, (k + 1) * 10, (k + 1) * 10);
    end
  endtask

  // Prescaler bypassed: one divider input cycle is 10 bus cycles
  task automatic test_divide;
    wr(cdd_pkg::IDX_SRC_SEL, 8'h01, cdd_pkg::RESP_OKAY);
    set_ch(2'h0, 8'h42, 8'h00, 8'h01);
    chk_wave(0, 30, 50);
    set_ch(2'h1, 8'hff, 8'h00, 8'h00);
    chk_wave(3, 160, 160);
    set_ch(2'h2, 8'h21, 8'h00, 8'h00);
    chk_wave(6, 25, 25);
    set_ch(2'h3, 8'h21, 8'h00, 8'h01);
    chk_wave(9, 20, 30);
    set_ch(2'h3, 8'h00, 8'h80, 8'h00);
    chk_wave(9, 5, 5);
  endtask

  task automatic test_zero_delay;
    set_ch(2'h0, 8'h11, 8'h00, 8'h00);
    wr(cdd_pkg::IDX_ZD_CFG, 8'h02, cdd_pkg::RESP_OKAY);
    // Flag is registered from the mode written one edge earlier
    @(posedge aclk);
    chk({31'h0, zd_active}, 32'h1);
    chk_wave(12, 20, 20);
    wr(cdd_pkg::IDX_ZD_CFG, 8'h1e, cdd_pkg::RESP_OKAY);
    rd_chk(cdd_pkg::IDX_STATUS, 32'h3, 32'h3);
    chk({30'h0, fb_channel}, 32'h3);
    chk_wave(12, 5, 5);
    wr(cdd_pkg::IDX_ZD_CFG, 8'h00, cdd_pkg::RESP_OKAY);
    @(posedge aclk);
    chk({31'h0, zd_active}, 32'h0);
    chk_wave(12, 6, 6);
  endtask

  // All four divide by four; channel 1 delayed two input cycles, channel 3 starts high
  task automatic test_sync;
    int n;
    set_ch(2'h1, 8'h11, 8'h02, 8'h00);
    set_ch(2'h2, 8'h11, 8'h00, 8'h00);
    set_ch(2'h3, 8'h11, 8'h10, 8'h00);
    wait_lvl(0, 1'b0, n);
    wait_lvl(0, 1'b1, n);
    wait_lvl(3, 1'b1, n);
    chk(32'(n), 32'd20);
    for (int i = 0; i < 8; i++) begin
      repeat (7) @(posedge aclk);
      chk({20'h0, clk_out[8:6], clk_out[11:9]}, {20'h0, clk_out[2:0], ~clk_out[2:0]});
    end
  endtask

  task automatic test_direct;
    wr(cdd_pkg::IDX_SRC_SEL, 8'h02, cdd_pkg::RESP_OKAY);
    set_ch(2'h2, 8'h00, 8'h00, 8'h02);
    chk_wave(6, 6, 6);
    chk_wave(8, 6, 6);
  endtask

  task automatic test_bad_src;
    logic [11:0] s;
    logic        moved;
    moved = 1'b0;
    wr(cdd_pkg::IDX_SRC_SEL, 8'h03, cdd_pkg::RESP_OKAY);
    rd_chk(cdd_pkg::IDX_STATUS, 32'h4, 32'h4);
    repeat (10) @(posedge aclk);
    s = clk_out;
    repeat (60) begin
      @(posedge aclk);
      if (clk_out !== s) moved = 1'b1;
    end
    chk({31'h0, moved}, 32'h0);
  endtask

  initial begin
    errors = 0;
    n_tests = 0;
    aresetn = 1'b0;
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
    {ext_clk_in, vco_clk_in, ext_cnt, vco_cnt} = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    test_reset;
    test_unmapped;
    test_prescale;
    test_divide;
    test_zero_delay;
    test_sync;
    test_direct;
    test_bad_src;
    test_done;
  end
endmodule
`default_nettype wire
